// file: hdl/pin_mux_pkg.sv
// Constants and carrier types for the port F to J override block
package pin_mux_pkg;

    // ------------------------------------------------------------
    // Override bundle for one eight-pin port
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] pullup_override_en;
        logic [7:0] pullup_override_val;
        logic [7:0] direction_override_en;
        logic [7:0] direction_override_val;
        logic [7:0] output_value_override_en;
        logic [7:0] output_value_override_val;
        logic [7:0] input_enable_override_en;
        logic [7:0] input_enable_override_val;
    } pin_override_t;

    // Test port state seen by the pin logic
    typedef struct packed {
        logic shift_ir;
        logic shift_dr;
        logic tdo;
    } test_port_state_t;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  CTRL_OFF        = 8'h00;
    localparam logic [7:0]  PC_MASK_OFF     = 8'h04;
    localparam logic [7:0]  LEVEL_OFF       = 8'h08;
    localparam logic [7:0]  IRQ_STATUS_OFF  = 8'h0c;
    localparam logic [7:0]  IRQ_MASK_OFF    = 8'h10;

    // Control fields and reset values
    localparam int          CTRL_TPE_BIT    = 0;
    localparam int          CTRL_PCGE_BIT   = 1;
    localparam logic [1:0]  CTRL_RESET      = 2'h0;

    // Level register field positions
    localparam int          LVL_F_LSB       = 0;
    localparam int          LVL_G_LSB       = 8;
    localparam int          LVL_H_LSB       = 16;
    localparam int          LVL_J_LSB       = 24;

    // ------------------------------------------------------------
    // Pin positions and pin-change numbering
    // ------------------------------------------------------------
    localparam int          F_TEST_LSB      = 4;
    localparam int          F_TDO_BIT       = 6;
    localparam int          F_TDI_BIT       = 7;
    localparam int          F_TMS_BIT       = 5;
    localparam int          F_TCK_BIT       = 4;
    localparam int          G_RESET_BIT     = 5;
    localparam int          G_T0_BIT        = 4;
    localparam int          G_T1_BIT        = 3;
    localparam int          G_WIDTH         = 6;
    localparam int          H_WIDTH         = 8;
    localparam int          J_WIDTH         = 7;
    localparam int          PC_H_BASE       = 16;
    localparam int          PC_J_BASE       = 24;
    localparam int          PC_TOP          = 30;
    localparam int          PC_COUNT        = PC_TOP - PC_H_BASE + 1;
    localparam logic [7:0]  F_TEST_MASK     = 8'hf0;
    localparam logic [7:0]  ALL_ONES8       = 8'hff;
    localparam logic [7:0]  ZERO8           = 8'h00;
    localparam logic        FUSE_PROGRAMMED = 1'b0;

    // AHB-Lite codes
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
    localparam logic        HRESP_OKAY      = 1'b0;

endpackage

// file: hdl/pin_mux_fj.sv
// Alternate-function override logic for ports F, G, H and J
//
// The register addresses and register access over AHB-Lite are this design's own decisions.
module pin_mux_fj #(
    parameter bit LARGE_VARIANT = 1'b1
) (
    hclk,
    hresetn,
    // AHB-Lite slave
    hsel,
    haddr,
    htrans,
    hwrite,
    hsize,
    hwdata,
    hready,
    hreadyout,
    hresp,
    hrdata,
    // Pad levels and fixed inputs
    pad_f_in,
    pad_g_in,
    pad_h_in,
    pad_j_in,
    reset_pin_disable_fuse_n,
    test_state,
    // Override bundles to the pin drivers
    f_override,
    g_override,
    h_override,
    j_override,
    // Peripheral side
    analog_pin_route,
    test_data_in,
    test_mode_select,
    test_clock,
    external_reset_n,
    port_g_bit5,
    timer0_count_source,
    timer1_count_source,
    pin_change_sources,
    irq
);

    // ------------------------------------------------------------
    // Ports
    // ------------------------------------------------------------
    input  wire logic                               hclk;
    input  wire logic                               hresetn;
    input  wire logic                               hsel;
    input  wire logic [31:0]                        haddr;
    input  wire logic [1:0]                         htrans;
    input  wire logic                               hwrite;
    input  wire logic [2:0]                         hsize;
    input  wire logic [31:0]                        hwdata;
    input  wire logic                               hready;
    output logic                                    hreadyout;
    output logic                                    hresp;
    output logic [31:0]                             hrdata;
    input  wire logic [7:0]                         pad_f_in;
    input  wire logic [pin_mux_pkg::G_WIDTH-1:0]    pad_g_in;
    input  wire logic [pin_mux_pkg::H_WIDTH-1:0]    pad_h_in;
    input  wire logic [pin_mux_pkg::J_WIDTH-1:0]    pad_j_in;
    input  wire logic                               reset_pin_disable_fuse_n;
    input  wire pin_mux_pkg::test_port_state_t      test_state;
    output pin_mux_pkg::pin_override_t              f_override;
    output pin_mux_pkg::pin_override_t              g_override;
    output pin_mux_pkg::pin_override_t              h_override;
    output pin_mux_pkg::pin_override_t              j_override;
    output logic [7:0]                              analog_pin_route;
    output logic                                    test_data_in;
    output logic                                    test_mode_select;
    output logic                                    test_clock;
    output logic                                    external_reset_n;
    output logic                                    port_g_bit5;
    output logic                                    timer0_count_source;
    output logic                                    timer1_count_source;
    output logic [pin_mux_pkg::PC_TOP:pin_mux_pkg::PC_H_BASE]
                                                    pin_change_sources;
    output logic                                    irq;

    localparam int PCN = pin_mux_pkg::PC_COUNT;

    // ------------------------------------------------------------
    // Internal state
    // ------------------------------------------------------------
    logic [1:0]                         ctrl_reg;
    logic [PCN-1:0]                     pc_mask_reg;
    logic [PCN-1:0]                     irq_status_reg;
    logic [PCN-1:0]                     irq_status_next;
    logic [PCN-1:0]                     irq_mask_reg;
    logic [PCN-1:0]                     pc_level_reg;
    logic [PCN-1:0]                     pc_level_next;
    logic [PCN-1:0]                     pc_event;
    logic                               wr_pend_reg;
    logic [pin_mux_pkg::ADDR_W-1:0]     wr_addr_reg;
    logic                               addr_phase;
    logic [pin_mux_pkg::ADDR_W-1:0]     a_off;
    logic [31:0]                        level_word;
    logic                               test_en;
    logic                               group_en;
    logic                               tdo_drive;
    pin_mux_pkg::pin_override_t         f_next;
    pin_mux_pkg::pin_override_t         g_next;
    pin_mux_pkg::pin_override_t         h_next;
    pin_mux_pkg::pin_override_t         j_next;

    // Pin-change input override for one port
    function automatic pin_mux_pkg::pin_override_t pc_override(
        input logic [7:0] mask,
        input logic       enable
    );
        pin_mux_pkg::pin_override_t o;
        o = '0;
        o.input_enable_override_en  = mask & {8{enable}};
        o.input_enable_override_val = pin_mux_pkg::ZERO8;
        return o;
    endfunction

    // Read data for one register offset
    function automatic logic [31:0] read_word(
        input logic [pin_mux_pkg::ADDR_W-1:0] off
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (off)
            pin_mux_pkg::CTRL_OFF:       w[1:0] = ctrl_reg;
            pin_mux_pkg::PC_MASK_OFF:    w[PCN-1:0] = pc_mask_reg;
            pin_mux_pkg::LEVEL_OFF:      w = level_word;
            pin_mux_pkg::IRQ_STATUS_OFF: w[PCN-1:0] = irq_status_reg;
            pin_mux_pkg::IRQ_MASK_OFF:   w[PCN-1:0] = irq_mask_reg;
            default:                     w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    assign addr_phase = hsel & hready & (htrans == pin_mux_pkg::HTRANS_NONSEQ);
    assign a_off      = haddr[pin_mux_pkg::ADDR_W-1:0];

    // Zero-wait slave, always OKAY
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b0;
            hresp     <= pin_mux_pkg::HRESP_OKAY;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= pin_mux_pkg::HRESP_OKAY;
        end
    end

    // Address phase capture for writes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
        end
        else
        begin
            wr_pend_reg <= addr_phase & hwrite;
            wr_addr_reg <= a_off;
        end
    end

    // Read data sampled at the address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (addr_phase && !hwrite)
            hrdata <= read_word(a_off);
    end

    // Writable control registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_reg     <= pin_mux_pkg::CTRL_RESET;
            pc_mask_reg  <= '0;
            irq_mask_reg <= '0;
        end
        else if (wr_pend_reg)
        begin
            if (wr_addr_reg == pin_mux_pkg::CTRL_OFF)
                ctrl_reg <= hwdata[1:0];
            if (wr_addr_reg == pin_mux_pkg::PC_MASK_OFF)
                pc_mask_reg <= hwdata[PCN-1:0];
            if (wr_addr_reg == pin_mux_pkg::IRQ_MASK_OFF)
                irq_mask_reg <= hwdata[PCN-1:0];
        end
    end

    assign test_en  = ctrl_reg[pin_mux_pkg::CTRL_TPE_BIT];
    assign group_en = ctrl_reg[pin_mux_pkg::CTRL_PCGE_BIT];

    // ------------------------------------------------------------
    // Pin-change sources, events and interrupt
    // ------------------------------------------------------------
    generate
        if (LARGE_VARIANT)
        begin : g_large
            // Source 16+n from H bit n, 24+n from J bit n
            assign pc_level_next = {pad_j_in, pad_h_in};
        end
        else
        begin : g_small
            // No H or J pins in the smaller variant
            assign pc_level_next = '0;
        end
    endgenerate

    // Edge on an enabled, unmasked source
    assign pc_event = (pc_level_reg ^ pc_level_next) & pc_mask_reg
                      & {PCN{group_en}};

    // Set beats write-one-clear
    always_comb
    begin
        irq_status_next = irq_status_reg;
        if (wr_pend_reg && wr_addr_reg == pin_mux_pkg::IRQ_STATUS_OFF)
            irq_status_next = irq_status_next & ~hwdata[PCN-1:0];
        irq_status_next = irq_status_next | pc_event;
    end

    // Source levels, sticky status and interrupt line
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pc_level_reg       <= '0;
            pin_change_sources <= '0;
            irq_status_reg     <= '0;
            irq                <= 1'b0;
        end
        else
        begin
            pc_level_reg       <= pc_level_next;
            pin_change_sources <= pc_level_next;
            irq_status_reg     <= irq_status_next;
            irq                <= |(irq_status_next & irq_mask_reg);
        end
    end

    // ------------------------------------------------------------
    // Port F overrides
    // ------------------------------------------------------------
    assign tdo_drive = test_state.shift_ir | test_state.shift_dr;

    // Test pins in F7..F4, nothing on F3..F0
    always_comb
    begin
        f_next = '0;
        if (test_en)
        begin
            f_next.pullup_override_en  = pin_mux_pkg::F_TEST_MASK;
            f_next.pullup_override_val = pin_mux_pkg::F_TEST_MASK;
            f_next.direction_override_en = pin_mux_pkg::F_TEST_MASK;
            f_next.input_enable_override_en = pin_mux_pkg::F_TEST_MASK;
            f_next.input_enable_override_val = pin_mux_pkg::ZERO8;
            // Data out driven while shifting, else left pulled up
            f_next.direction_override_val[pin_mux_pkg::F_TDO_BIT] =
                tdo_drive;
            f_next.output_value_override_en[pin_mux_pkg::F_TDO_BIT] =
                1'b1;
            f_next.output_value_override_val[pin_mux_pkg::F_TDO_BIT] =
                test_state.tdo;
        end
    end

    // ------------------------------------------------------------
    // Port G overrides
    // ------------------------------------------------------------
    // G5 input only with pull-up on; G4, G3 untouched
    always_comb
    begin
        g_next = '0;
        g_next.pullup_override_en[pin_mux_pkg::G_RESET_BIT]    = 1'b1;
        g_next.pullup_override_val[pin_mux_pkg::G_RESET_BIT]   = 1'b1;
        g_next.direction_override_en[pin_mux_pkg::G_RESET_BIT] = 1'b1;
        g_next.direction_override_val[pin_mux_pkg::G_RESET_BIT] = 1'b0;
        g_next.output_value_override_en[pin_mux_pkg::G_RESET_BIT] =
            1'b1;
        g_next.output_value_override_val[pin_mux_pkg::G_RESET_BIT] =
            1'b0;
    end

    // ------------------------------------------------------------
    // Ports H and J overrides
    // ------------------------------------------------------------
    generate
        if (LARGE_VARIANT)
        begin : g_hj
            assign h_next = pc_override(pc_mask_reg[7:0],
                                        group_en);
            assign j_next = pc_override(
                {1'b0, pc_mask_reg[PCN-1:pin_mux_pkg::H_WIDTH]},
                group_en);
        end
        else
        begin : g_no_hj
            assign h_next = '0;
            assign j_next = '0;
        end
    endgenerate

    // Registered override bundles
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            f_override <= '0;
            g_override <= '0;
            h_override <= '0;
            j_override <= '0;
        end
        else
        begin
            f_override <= f_next;
            g_override <= g_next;
            h_override <= h_next;
            j_override <= j_next;
        end
    end

    // ------------------------------------------------------------
    // Peripheral inputs
    // ------------------------------------------------------------
    // Pin levels forwarded to converter, test port and timers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            analog_pin_route    <= pin_mux_pkg::ZERO8;
            test_data_in        <= 1'b1;
            test_mode_select    <= 1'b1;
            test_clock          <= 1'b0;
            timer0_count_source <= 1'b0;
            timer1_count_source <= 1'b0;
        end
        else
        begin
            analog_pin_route    <= pad_f_in;
            test_data_in        <= pad_f_in[pin_mux_pkg::F_TDI_BIT];
            test_mode_select    <= pad_f_in[pin_mux_pkg::F_TMS_BIT];
            test_clock          <= pad_f_in[pin_mux_pkg::F_TCK_BIT];
            timer0_count_source <= pad_g_in[pin_mux_pkg::G_T0_BIT];
            timer1_count_source <= pad_g_in[pin_mux_pkg::G_T1_BIT];
        end
    end

    // G5 always as plain input, and as reset input unless the fuse is programmed
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            external_reset_n <= 1'b1;
            port_g_bit5      <= 1'b1;
        end
        else
        begin
            port_g_bit5 <= pad_g_in[pin_mux_pkg::G_RESET_BIT];
            if (reset_pin_disable_fuse_n == pin_mux_pkg::FUSE_PROGRAMMED)
                external_reset_n <= 1'b1;
            else
                external_reset_n <= pad_g_in[pin_mux_pkg::G_RESET_BIT];
        end
    end

    // ------------------------------------------------------------
    // Level register view
    // ------------------------------------------------------------
    always_comb
    begin
        level_word = 32'h0000_0000;
        level_word[pin_mux_pkg::LVL_F_LSB +: 8] = pad_f_in;
        level_word[pin_mux_pkg::LVL_G_LSB +: pin_mux_pkg::G_WIDTH] = pad_g_in;
        level_word[pin_mux_pkg::LVL_H_LSB +: pin_mux_pkg::H_WIDTH] =
            pc_level_reg[pin_mux_pkg::H_WIDTH-1:0];
        level_word[pin_mux_pkg::LVL_J_LSB +: pin_mux_pkg::J_WIDTH] =
            pc_level_reg[PCN-1:pin_mux_pkg::H_WIDTH];
    end

endmodule

// file: tb/pad_model.sv
// Pad levels and test port sources facing the override block
module pad_model (
    input  wire logic                       hclk,
    output logic [7:0]                      pad_f_in,
    output logic [pin_mux_pkg::G_WIDTH-1:0] pad_g_in,
    output logic [pin_mux_pkg::H_WIDTH-1:0] pad_h_in,
    output logic [pin_mux_pkg::J_WIDTH-1:0] pad_j_in,
    output logic                            reset_pin_disable_fuse_n,
    output pin_mux_pkg::test_port_state_t   test_state
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet pads, fuse left unprogrammed, test port idle
    initial
    begin
        pad_f_in = 8'h00;
        pad_g_in = '0;
        pad_h_in = '0;
        pad_j_in = '0;
        reset_pin_disable_fuse_n = 1'b1;
        test_state = 3'h1;
    end

    // New pad levels land just after a rising edge
    task automatic drive(logic [7:0] f, logic [5:0] g, logic [7:0] h,
                         logic [6:0] j);
        @(posedge hclk);
        pad_f_in <= f;
        pad_g_in <= g;
        pad_h_in <= h;
        pad_j_in <= j;
    endtask

    // Test port state and fuse change together
    task automatic set_test(logic [2:0] ts, logic fuse_n);
        @(posedge hclk);
        test_state <= ts;
        reset_pin_disable_fuse_n <= fuse_n;
    endtask
endmodule

// file: tb/pin_mux_fj_asserts.sv
// Concurrent checks on the port F to J override block
module pin_mux_fj_asserts (
    input wire logic         hclk,
    input wire logic         hresetn,
    input wire logic         hreadyout,
    input wire logic         hresp,
    input wire logic [7:0]   pad_f_in,
    input wire logic [5:0]   pad_g_in,
    input wire logic [7:0]   pad_h_in,
    input wire logic [6:0]   pad_j_in,
    input wire logic         reset_pin_disable_fuse_n,
    input wire pin_mux_pkg::test_port_state_t test_state,
    input wire pin_mux_pkg::pin_override_t f_override,
    input wire pin_mux_pkg::pin_override_t g_override,
    input wire pin_mux_pkg::pin_override_t h_override,
    input wire pin_mux_pkg::pin_override_t j_override,
    input wire logic [7:0]   analog_pin_route,
    input wire logic         external_reset_n,
    input wire logic         port_g_bit5,
    input wire logic         timer0_count_source,
    input wire logic         timer1_count_source,
    input wire logic [30:16] pin_change_sources,
    input wire logic         irq
);
    logic up_reg;

    // High from the first edge after reset release
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            up_reg <= 1'b0;
        else
            up_reg <= 1'b1;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_bus_okay: assert property (up_reg |-> hreadyout && !hresp)
        else $error("bus not ready or not okay");
    a_f_low_clean: assert property (up_reg |->
        (f_override & 64'h0f0f0f0f0f0f0f0f) == 64'h0 &&
        analog_pin_route == $past(pad_f_in))
        else $error("low F pins overridden or misrouted");
    a_f_test_fields: assert property (up_reg |->
        f_override[63:56] inside {8'h00, 8'hf0} &&
        f_override[55:48] == f_override[63:56] &&
        f_override[47:40] == f_override[63:56] &&
        f_override[15:8] == f_override[63:56] && f_override[7:0] == 8'h0)
        else $error("test pin override fields wrong");
    a_tdo_drive: assert property (up_reg |->
        f_override[31:24] == (f_override[63:56] & 8'h40) &&
        f_override[23:16] == (f_override[31:24] &
            {1'b0, $past(test_state.tdo), 6'h0}) &&
        f_override[39:32] == (f_override[31:24] &
            {1'b0, $past(test_state.shift_ir | test_state.shift_dr), 6'h0}))
        else $error("test data out drive wrong");
    a_g5_input: assert property (up_reg |->
        g_override == 64'h2020200020000000)
        else $error("G overrides wrong");
    a_reset_fuse: assert property (up_reg |->
        external_reset_n == ($past(reset_pin_disable_fuse_n) ?
            $past(pad_g_in[5]) : 1'b1) && port_g_bit5 == $past(pad_g_in[5]))
        else $error("reset pin routing wrong");
    a_timer_route: assert property (up_reg |->
        timer0_count_source == $past(pad_g_in[4]) &&
        timer1_count_source == $past(pad_g_in[3]))
        else $error("timer sources wrong");
    a_pc_route: assert property (up_reg |->
        pin_change_sources == $past({pad_j_in, pad_h_in}))
        else $error("pin change sources wrong");
    a_hj_only_inen: assert property (up_reg |->
        {h_override[63:16], h_override[7:0]} == 56'h0 &&
        {j_override[63:15], j_override[7:0]} == 57'h0)
        else $error("H or J override beyond input enable");

    c_tdo_drive: cover property (f_override[31:24] != 8'h00);
    c_irq_rise: cover property ($rose(irq));
    c_fuse_prog: cover property (!reset_pin_disable_fuse_n);
endmodule

bind pin_mux_fj pin_mux_fj_asserts chk (.*);

// file: tb/tb_pin_mux_fj.sv
// Self-checking bench for the port F to J override block
`define CHECK(n, g, e) check_val(n, 64'(g), 64'(e))
module tb_pin_mux_fj;
    timeunit 1ns;
    timeprecision 1ps;
    logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic         fuse_n, ext_rst_n, g5, t0, t1;
    logic [1:0]   htrans;
    logic [2:0]   hsize, ts, tp;
    logic [5:0]   g_in;
    logic [6:0]   j_in;
    logic [7:0]   f_in, h_in, route;
    logic [31:0]  haddr, hwdata, hrdata, rd;
    logic [30:16] pcs;
    logic [63:0]  f_ov, g_ov, h_ov, j_ov;
    int           err_count, total_checks;

    pin_mux_fj dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .pad_f_in(f_in), .pad_g_in(g_in), .pad_h_in(h_in),
        .pad_j_in(j_in), .reset_pin_disable_fuse_n(fuse_n),
        .test_state(ts), .f_override(f_ov), .g_override(g_ov),
        .h_override(h_ov), .j_override(j_ov), .analog_pin_route(route),
        .test_data_in(tp[2]), .test_mode_select(tp[1]), .test_clock(tp[0]),
        .external_reset_n(ext_rst_n), .port_g_bit5(g5),
        .timer0_count_source(t0), .timer1_count_source(t1),
        .pin_change_sources(pcs), .irq);

    pad_model pads (.hclk, .pad_f_in(f_in), .pad_g_in(g_in),
        .pad_h_in(h_in), .pad_j_in(j_in),
        .reset_pin_disable_fuse_n(fuse_n), .test_state(ts));

    // 200 MHz clock
    initial
    begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check_val(string n, logic [63:0] g, logic [63:0] e);
        total_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge hclk);
    endtask

    // Waits for an edge with hready high, bounded
    task automatic bus_wait();
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1)
        begin
            err_count++;
            end_of_test();
        end
    endtask

    task automatic write_reg(logic [7:0] a, logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= pin_mux_pkg::HTRANS_NONSEQ;
        hwrite <= 1'b1;
        bus_wait();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        bus_wait();
    endtask

    task automatic read_reg(logic [7:0] a, output logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= pin_mux_pkg::HTRANS_NONSEQ;
        hwrite <= 1'b0;
        bus_wait();
        hsel <= 1'b0;
        htrans <= 2'h0;
        bus_wait();
        d = hrdata;
    endtask

    // Main sequence
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        err_count = 0;
        total_checks = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        tick(2);
        read_reg(pin_mux_pkg::CTRL_OFF, rd);
        `CHECK("ctrl reset", rd, 32'h0);
        `CHECK("f idle", f_ov, 64'h0);
        `CHECK("g fixed", g_ov, 64'h2020200020000000);
        // Pad routing, read-only level word, unmapped place
        pads.drive(8'h5a, 6'h18, 8'ha5, 7'h5a);
        tick(2);
        `CHECK("analog", route, 8'h5a);
        `CHECK("timers", {t0, t1}, 2'b11);
        `CHECK("pc src", pcs, 15'h5aa5);
        `CHECK("test pins", tp, 3'b001);
        write_reg(pin_mux_pkg::LEVEL_OFF, 32'hffffffff);
        read_reg(pin_mux_pkg::LEVEL_OFF, rd);
        `CHECK("level", rd, 32'h5aa5185a);
        read_reg(8'h20, rd);
        `CHECK("unmapped", rd, 32'h0);
        pads.drive(8'h5a, 6'h08, 8'ha5, 7'h5a);
        tick(2);
        `CHECK("timers2", {t0, t1}, 2'b01);
        `CHECK("ext rst", ext_rst_n, 1'b0);
        // Programmed fuse keeps reset inactive
        pads.set_test(3'h1, 1'b0);
        tick(2);
        `CHECK("fuse rst", ext_rst_n, 1'b1);
        `CHECK("g5 in", g5, 1'b0);
        pads.drive(8'h5a, 6'h28, 8'ha5, 7'h5a);
        tick(2);
        `CHECK("g5 high", g5, 1'b1);
        // Test port: every shift state, data level the inverse of shift_dr
        write_reg(pin_mux_pkg::CTRL_OFF, 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            pads.set_test({i[1:0], ~i[0]}, 1'b1);
            tick(2);
            `CHECK("f test", f_ov, {24'hf0f0f0, 1'b0, |i[1:0],
                15'h0080, ~i[0], 22'h00f000});
        end
        // Input enable overrides follow mask and group enable
        write_reg(pin_mux_pkg::PC_MASK_OFF, 32'h2a55);
        write_reg(pin_mux_pkg::CTRL_OFF, 32'h2);
        tick(2);
        `CHECK("h inen", h_ov, 64'h5500);
        `CHECK("j inen", j_ov, 64'h2a00);
        `CHECK("f off", f_ov, 64'h0);
        write_reg(pin_mux_pkg::CTRL_OFF, 32'h0);
        tick(2);
        `CHECK("h none", h_ov, 64'h0);
        // Change events: set, mask, clear
        pads.drive(8'h5a, 6'h28, 8'ha4, 7'h5a);
        tick(2);
        read_reg(pin_mux_pkg::IRQ_STATUS_OFF, rd);
        `CHECK("no group", rd, 32'h0);
        write_reg(pin_mux_pkg::PC_MASK_OFF, 32'h7fff);
        write_reg(pin_mux_pkg::CTRL_OFF, 32'h2);
        write_reg(pin_mux_pkg::IRQ_MASK_OFF, 32'h1);
        pads.drive(8'h5a, 6'h28, 8'ha7, 7'h5a);
        tick(2);
        `CHECK("irq on", irq, 1'b1);
        read_reg(pin_mux_pkg::IRQ_STATUS_OFF, rd);
        `CHECK("status", rd, 32'h3);
        write_reg(pin_mux_pkg::IRQ_STATUS_OFF, 32'h1);
        tick(2);
        `CHECK("irq masked", irq, 1'b0);
        write_reg(pin_mux_pkg::IRQ_MASK_OFF, 32'h2);
        tick(2);
        `CHECK("irq unmask", irq, 1'b1);
        write_reg(pin_mux_pkg::IRQ_STATUS_OFF, 32'h2);
        tick(2);
        `CHECK("irq clear", irq, 1'b0);
        pads.drive(8'h5a, 6'h28, 8'ha7, 7'h5b);
        tick(2);
        read_reg(pin_mux_pkg::IRQ_STATUS_OFF, rd);
        `CHECK("j status", rd, 32'h100);
        end_of_test();
    end
endmodule
